/* rtl/seg_time_cfg.svh */
`ifndef SEG_TIME_CFG_SVH
`define SEG_TIME_CFG_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define IDX_SEG_5_6 8'h61
`define IDX_SEG_7_8 8'h62
`define IDX_SEG_9_10 8'h63
`define IDX_SEG_11_12 8'h64
`define IDX_EARLY 8'h70
`define IDX_POINT_SEL 8'h71
`define IDX_POINT_ABS 8'h72

// ==========================================================
// storage word slots
`define WORD_SEG_5_6 3'h0
`define WORD_SEG_7_8 3'h1
`define WORD_SEG_9_10 3'h2
`define WORD_SEG_11_12 3'h3
`define WORD_EARLY 3'h4
`define NUM_WORDS 5
`define NUM_SEG_WORDS 4

// ==========================================================
// field positions
`define SEG_HI 7:4
`define SEG_LO 3:0
`define SEG_BYTE 7:0
`define EARLY_FIRST 15:12
`define EARLY_D2 11:8
`define EARLY_D3 7:4
`define EARLY_D4 3:0
`define EARLY_BITS 15:0
`define SEL_BITS 3:0
`define ADDR_IDX 9:2
`define ADDR_LOW 1:0
`define ADDR_HIGH 11:10

// ==========================================================
// point selection and durations in microseconds, code 15 first
`define NUM_POINTS 12
`define POINT_FIRST 4'h1
`define POINT_LAST 4'hc
`define POINT_SEL_RST 4'h1
`define DUR_MAX 17'h01f40
`define SEG_DUR_TABLE {16'h1f40, 16'h1900, 16'h1450, 16'h0fa0, 16'h0c80, 16'h0960, \
    16'h07d0, 16'h0578, 16'h04b0, 16'h03e8, 16'h0320, 16'h0258, 16'h0190, 16'h012c, \
    16'h00c8, 16'h0064}

`endif

/* rtl/seg_time_pkg.sv */
`include "seg_time_cfg.svh"

package seg_time_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_RESP = 2'h3
    } apb_state_type;

    typedef logic [3:0] seg_code_type;
    typedef logic [15:0] dur_us_type;

    typedef struct packed {
        logic hit;
        logic is_mem;
        logic is_early;
        logic is_sel;
        logic is_abs;
        logic [2:0] word;
    } decode_type;

    function automatic dur_us_type seg_dur(input seg_code_type code);
        logic [255:0] table_us;
        table_us = `SEG_DUR_TABLE;
        return table_us[{code, 4'h0} +: 16];
    endfunction

endpackage

/* rtl/seg_store_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface seg_store_if #(
    parameter int DW = 16,
    parameter int N = 5
);
    logic we;
    logic [2:0] waddr;
    logic [DW-1:0] wdata;
    logic [2:0] raddr;
    logic [DW-1:0] rdata;
    logic [DW*N-1:0] words;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata, input words);
    modport store (input we, input waddr, input wdata, input raddr, output rdata, output words);
endinterface

`default_nettype wire

/* rtl/seg_time_store.sv */
`timescale 1ns/1ns
`default_nettype none

module seg_time_store #(
    parameter int DW = 16,
    parameter int N = 5
) (
    input wire logic clk,
    input wire logic rst,
    seg_store_if.store port
);

    // ==========================================================
    // storage
    // no reset on purpose: contents are unknown until written
    logic [DW-1:0] mem [N];
    logic [DW-1:0] rdata_ff;
    logic [DW-1:0] nxt_rdata;

    always_ff @(posedge clk) begin
        if (port.we && (int'(port.waddr) < N)) begin
            mem[port.waddr] <= port.wdata;
        end
    end

    always_comb begin
        nxt_rdata = '0;
        if (int'(port.raddr) < N) begin
            nxt_rdata = mem[port.raddr];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign port.rdata = rdata_ff;

    for (genvar g = 0; g < N; g++) begin : g_words
        assign port.words[g*DW +: DW] = mem[g];
    end

endmodule

`default_nettype wire

/* rtl/threshold_segment_time_regs.sv */
// Implementation choice: register access over APB.
`include "seg_time_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module threshold_segment_time_regs #(
    parameter int AW = 12
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [16:0] POINT_ABS_US
);

    // ==========================================================
    // address decode
    function automatic seg_time_pkg::decode_type addr_decode(input logic [AW-1:0] a);
        seg_time_pkg::decode_type d;
        d = '0;
        if (a[`ADDR_LOW] == 2'h0 && a[`ADDR_HIGH] == 2'h0) begin
            case (a[`ADDR_IDX])
                `IDX_SEG_5_6: begin
                    d.hit = 1'b1;
                    d.is_mem = 1'b1;
                    d.word = `WORD_SEG_5_6;
                end
                `IDX_SEG_7_8: begin
                    d.hit = 1'b1;
                    d.is_mem = 1'b1;
                    d.word = `WORD_SEG_7_8;
                end
                `IDX_SEG_9_10: begin
                    d.hit = 1'b1;
                    d.is_mem = 1'b1;
                    d.word = `WORD_SEG_9_10;
                end
                `IDX_SEG_11_12: begin
                    d.hit = 1'b1;
                    d.is_mem = 1'b1;
                    d.word = `WORD_SEG_11_12;
                end
                `IDX_EARLY: begin
                    d.hit = 1'b1;
                    d.is_mem = 1'b1;
                    d.is_early = 1'b1;
                    d.word = `WORD_EARLY;
                end
                `IDX_POINT_SEL: begin
                    d.hit = 1'b1;
                    d.is_sel = 1'b1;
                end
                `IDX_POINT_ABS: begin
                    d.hit = 1'b1;
                    d.is_abs = 1'b1;
                end
                default: begin
                    d.hit = 1'b0;
                end
            endcase
        end
        return d;
    endfunction

    seg_store_if #(.DW(16), .N(`NUM_WORDS)) st ();

    seg_time_store #(.DW(16), .N(`NUM_WORDS)) u_store (
        .clk(CORE_CLK),
        .rst(RST),
        .port(st)
    );

    seg_time_pkg::decode_type dec;
    seg_time_pkg::apb_state_type state_ff, nxt_state;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [3:0] sel_ff, nxt_sel;
    logic [16:0] abs_ff, nxt_abs;
    logic [`NUM_WORDS-1:0] known_ff, nxt_known;
    logic [15:0] early_word;
    seg_time_pkg::seg_code_type code [`NUM_POINTS];

    assign dec = addr_decode(PADDR);
    assign st.raddr = dec.word;
    assign st.waddr = dec.word;
    assign st.wdata = dec.is_early ? PWDATA[`EARLY_BITS] : {8'h00, PWDATA[`SEG_BYTE]};

    // ==========================================================
    // code unpacking: point 1 absolute, points 2..12 deltas
    assign early_word = st.words[`WORD_EARLY*16 +: 16];
    assign code[0] = early_word[`EARLY_FIRST];
    assign code[1] = early_word[`EARLY_D2];
    assign code[2] = early_word[`EARLY_D3];
    assign code[3] = early_word[`EARLY_D4];

    for (genvar g = 0; g < `NUM_SEG_WORDS; g++) begin : g_codes
        assign code[4+2*g] = st.words[g*16 + 4 +: 4];
        assign code[5+2*g] = st.words[g*16 +: 4];
    end

    // ==========================================================
    // apb slave: one wait state, answer in second access cycle
    always_comb begin
        nxt_state = state_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        nxt_sel = sel_ff;
        st.we = 1'b0;
        case (state_ff)
            seg_time_pkg::ST_IDLE: begin
                if (PSEL) begin
                    nxt_state = seg_time_pkg::ST_WAIT;
                end
            end
            seg_time_pkg::ST_WAIT: begin
                nxt_state = seg_time_pkg::ST_RESP;
                nxt_pready = 1'b1;
                // the computed time is read-only; writing it is an error
                nxt_pslverr = !dec.hit || (PWRITE && dec.is_abs);
                nxt_prdata = '0;
                if (!PWRITE) begin
                    if (dec.is_mem && dec.is_early) begin
                        nxt_prdata = {16'h0000, st.rdata};
                    end else if (dec.is_mem) begin
                        nxt_prdata = {24'h000000, st.rdata[`SEG_BYTE]};
                    end else if (dec.is_sel) begin
                        nxt_prdata = {28'h0000000, sel_ff};
                    end else if (dec.is_abs) begin
                        nxt_prdata = {15'h0000, abs_ff};
                    end
                end
            end
            seg_time_pkg::ST_RESP: begin
                nxt_state = seg_time_pkg::ST_IDLE;
                if (PSEL && PENABLE && PWRITE) begin
                    st.we = dec.is_mem;
                    if (dec.is_sel && PWDATA[`SEL_BITS] >= `POINT_FIRST
                            && PWDATA[`SEL_BITS] <= `POINT_LAST) begin
                        nxt_sel = PWDATA[`SEL_BITS];
                    end
                end
            end
            default: begin
                nxt_state = seg_time_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_ff <= seg_time_pkg::ST_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
            sel_ff <= `POINT_SEL_RST;
        end else begin
            state_ff <= nxt_state;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            sel_ff <= nxt_sel;
        end
    end

    // ==========================================================
    // absolute time of the selected point
    // deltas accumulate on the previous point, never from listen start
    always_comb begin
        nxt_abs = '0;
        for (int i = 0; i < `NUM_POINTS; i++) begin
            if (4'(i) < sel_ff) begin
                nxt_abs = nxt_abs + {1'b0, seg_time_pkg::seg_dur(code[i])};
            end
        end
    end

    // known only guards the checks below against unwritten storage
    always_comb begin
        nxt_known = known_ff;
        if (st.we) begin
            nxt_known[st.waddr] = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            abs_ff <= '0;
            known_ff <= '0;
        end else begin
            abs_ff <= nxt_abs;
            known_ff <= nxt_known;
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign POINT_ABS_US = abs_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_first_access;
        PSEL && PENABLE && !PREADY;
    endsequence

    sequence s_write_done(logic [2:0] w);
        PSEL && PENABLE && PREADY && PWRITE && dec.is_mem && dec.word == w;
    endsequence

    property p_stored(logic [2:0] w);
        s_write_done(w) |=> st.words[w*16 +: 8] == $past(PWDATA[`SEG_BYTE]);
    endproperty

    a_apb_one_wait: assert property (s_setup ##1 s_first_access |=> PREADY)
        else $error("ready not given in second access cycle");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    a_seg56_write: assert property (p_stored(`WORD_SEG_5_6))
        else $error("write to fifth/sixth segment not stored");
    a_seg78_write: assert property (p_stored(`WORD_SEG_7_8))
        else $error("write to seventh/eighth segment not stored");
    a_seg910_write: assert property (p_stored(`WORD_SEG_9_10))
        else $error("write to ninth/tenth segment not stored");
    a_seg1112_write: assert property (p_stored(`WORD_SEG_11_12))
        else $error("write to eleventh/twelfth segment not stored");
    a_seg_read_width: assert property (state_ff == seg_time_pkg::ST_WAIT && !PWRITE
            && dec.is_mem && !dec.is_early |=> PRDATA[31:8] == 24'h000000
            && PRDATA[`SEG_BYTE] == $past(st.words[dec.word*16 +: 8]))
        else $error("segment read data wrong");
    a_first_absolute: assert property (known_ff[`WORD_EARLY] && sel_ff == `POINT_FIRST
            |=> POINT_ABS_US == {1'b0, seg_time_pkg::seg_dur($past(code[0]))})
        else $error("first point time not absolute");
    a_code_max: assert property (known_ff[`WORD_EARLY] && sel_ff == `POINT_FIRST
            && code[0] == 4'hf |=> POINT_ABS_US == `DUR_MAX)
        else $error("top code does not give longest duration");
    a_point6_sum: assert property (known_ff[`WORD_EARLY] && known_ff[`WORD_SEG_5_6]
            && sel_ff == 4'h6 |=> POINT_ABS_US == $past(17'(seg_time_pkg::seg_dur(code[0]))
            + 17'(seg_time_pkg::seg_dur(code[1])) + 17'(seg_time_pkg::seg_dur(code[2]))
            + 17'(seg_time_pkg::seg_dur(code[3])) + 17'(seg_time_pkg::seg_dur(code[4]))
            + 17'(seg_time_pkg::seg_dur(code[5]))))
        else $error("sixth point time is not the accumulated sum");

endmodule

`default_nettype wire

/* dv/threshold_segment_time_regs_bench.sv */
`include "seg_time_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module threshold_segment_time_regs_bench;
    typedef struct packed {
        logic [31:0] data;
        logic err;
        logic rd;
        logic abs;
    } note_type;

    localparam int dur_tab [16] = '{100, 200, 300, 400, 600, 800, 1000, 1200, 1400, 2000,
        2400, 3200, 4000, 5200, 6400, 8000};

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [16:0] point_abs_us;
    int bad_count = 0;
    int comparisons = 0;
    note_type notes [$];
    logic [15:0] lfsr_state = 16'h0009;

    threshold_segment_time_regs #(.AW(12)) uut (
        .CORE_CLK(core_clk),
        .RST(rst),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .POINT_ABS_US(point_abs_us)
    );

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    // ==========================================================
    // shared tasks
    function automatic logic [15:0] next_rand();
        lfsr_state = {lfsr_state[14:0],
            lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
        return lfsr_state;
    endfunction

    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // entered just after a rising edge; leaves the bus held for a back-to-back setup
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
            input logic [31:0] exp, input logic err);
        note_type n;
        int k;
        n.data = exp;
        n.err = err;
        n.rd = !wr;
        n.abs = !wr && (addr == ad(`IDX_POINT_ABS));
        notes.push_back(n);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // ready is looked at as it stands at the rising edge, before the edge updates it
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            bad_count++;
            $display("[FAIL] %0t no ready within bound", $time);
            finish_test();
        end
    endtask

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // ==========================================================
    // response monitor
    always @(negedge core_clk) begin
        note_type n;
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                bad_count++;
                $display("[FAIL] %0t response without request", $time);
            end else begin
                n = notes.pop_front();
                check({31'h0, pslverr}, {31'h0, n.err});
                if (n.rd) check(prdata, n.data);
                if (n.abs) check({15'h0, point_abs_us}, n.data);
            end
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        int i;
        int sum;
        logic [15:0] r;
        logic [3:0] codes [1:12];
        repeat (10) @(posedge core_clk);
        check({30'h0, pready, pslverr}, 32'h0);
        check(prdata, 32'h0);
        check({15'h0, point_abs_us}, 32'h0);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, ad(`IDX_POINT_SEL), 32'h0, 32'h1, 1'b0);
        // upper write bits set on purpose: they must read back as zero
        for (i = 0; i < 4; i++) begin
            r = next_rand();
            codes[5 + 2 * i] = r[7:4];
            codes[6 + 2 * i] = r[3:0];
            apb(1'b1, ad(8'(`IDX_SEG_5_6 + i)), {16'hffff, r}, 32'h0, 1'b0);
            apb(1'b0, ad(8'(`IDX_SEG_5_6 + i)), 32'h0, {24'h0, r[7:0]}, 1'b0);
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b0, ad(8'(`IDX_SEG_5_6 + i)), 32'h0,
                {24'h0, codes[5 + 2 * i], codes[6 + 2 * i]}, 1'b0);
        end
        r = next_rand();
        {codes[1], codes[2], codes[3], codes[4]} = r;
        apb(1'b1, ad(`IDX_EARLY), {16'h0, r}, 32'h0, 1'b0);
        apb(1'b0, ad(`IDX_EARLY), 32'h0, {16'h0, r}, 1'b0);
        sum = 0;
        for (i = 1; i <= 12; i++) begin
            sum += dur_tab[codes[i]];
            apb(1'b1, ad(`IDX_POINT_SEL), 32'(i), 32'h0, 1'b0);
            apb(1'b0, ad(`IDX_POINT_ABS), 32'h0, 32'(sum), 1'b0);
        end
        // out-of-range selects are dropped without an error
        apb(1'b1, ad(`IDX_POINT_SEL), 32'h0, 32'h0, 1'b0);
        apb(1'b1, ad(`IDX_POINT_SEL), 32'hd, 32'h0, 1'b0);
        apb(1'b0, ad(`IDX_POINT_SEL), 32'h0, 32'hc, 1'b0);
        apb(1'b1, ad(`IDX_POINT_SEL), 32'h1, 32'h0, 1'b0);
        for (i = 0; i < 16; i++) begin
            apb(1'b1, ad(`IDX_EARLY), {16'h0, 4'(i), 12'h0}, 32'h0, 1'b0);
            apb(1'b0, ad(`IDX_POINT_ABS), 32'h0, 32'(dur_tab[i]), 1'b0);
        end
        apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
        apb(1'b0, ad(`IDX_SEG_5_6) | 12'h001, 32'h0, 32'h0, 1'b1);
        apb(1'b0, ad(`IDX_SEG_5_6) | 12'h400, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h000, 32'h5a, 32'h0, 1'b1);
        apb(1'b1, ad(`IDX_POINT_ABS), 32'h5a, 32'h0, 1'b1);
        apb(1'b1, ad(`IDX_SEG_5_6) | 12'h002, 32'h5a, 32'h0, 1'b1);
        apb(1'b0, ad(`IDX_SEG_5_6), 32'h0, {24'h0, codes[5], codes[6]}, 1'b0);
        // second reset in mid-run: select must come back to its reset value
        idle();
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, ad(`IDX_POINT_SEL), 32'h0, 32'h1, 1'b0);
        // segment storage has no reset, so the last written codes survive it
        apb(1'b0, ad(`IDX_SEG_5_6), 32'h0, {24'h0, codes[5], codes[6]}, 1'b0);
        idle();
        repeat (3) @(posedge core_clk);
        if (notes.size() != 0) begin
            bad_count++;
            $display("[FAIL] %0t responses missing", $time);
        end
        finish_test();
    end
endmodule

`default_nettype wire
